// ===== hw/rtcag_map.svh
`ifndef RTCAG_MAP_SVH
`define RTCAG_MAP_SVH
// Register addresses
`define RTCAG_AW          9
`define RTCAG_DW          8
`define RTCAG_A_SEC       9'h170
`define RTCAG_A_MIN       9'h171
`define RTCAG_A_HR        9'h172
`define RTCAG_A_WK        9'h173
`define RTCAG_A_DAY       9'h174
`define RTCAG_A_MON       9'h175
`define RTCAG_A_YR        9'h176
`define RTCAG_A_CTRL      9'h177
`define RTCAG_A_IRQST     9'h178
`define RTCAG_A_IRQEN     9'h179
`define RTCAG_A_HRALM     9'h17d
`define RTCAG_A_WKALM     9'h17e
`define RTCAG_A_GUARD     9'h17f
// Field widths and positions
`define RTCAG_SEC_W       7
`define RTCAG_MIN_W       7
`define RTCAG_HR_W        6
`define RTCAG_WK_W        3
`define RTCAG_DAY_W       6
`define RTCAG_MON_W       5
`define RTCAG_YR_W        8
`define RTCAG_HRALM_W     7
`define RTCAG_EN_BIT      7
`define RTCAG_GUARD_BIT   7
`define RTCAG_RSVD_BIT    6
`define RTCAG_BUSY_BIT    7
`define RTCAG_SRST_BIT    0
`define RTCAG_MODE_BIT    1
`define RTCAG_HOUR_FORMAT_24_SEL_BIT    5
`define RTCAG_PM_BIT      6
`define RTCAG_ALF_BIT     0
`define RTCAG_WK_RSVD_MSK 8'h78
`define RTCAG_GD_RSVD_MSK 8'h3f
`define RTCAG_RST_BYTE    8'h00
`endif

// ===== hw/rtcag_pkg.sv
package rtcag_pkg;
	// Timer operating mode
	typedef enum logic {
		RTCAG_MODE_RTC,
		RTCAG_MODE_CMT
	} rtcag_mode_t;
endpackage

// ===== hw/rtcag_alarm_match.sv
`timescale 1ns/1ps
`default_nettype none
module rtcag_alarm_match (
	input  wire logic       rtc_mode_i,
	input  wire logic       hour_alarm_en_i,
	input  wire logic [6:0] hour_alarm_val_i,
	input  wire logic       afternoon_indicator_i,
	input  wire logic [5:0] hours_counter_i,
	input  wire logic       weekday_alarm_en_i,
	input  wire logic [2:0] weekday_alarm_code_i,
	input  wire logic [2:0] weekday_counter_i,
	output logic            match_o
);
	logic hr_eq;
	logic wk_eq;
	logic any_en;

	// (RULE14) hour field incl. afternoon
	assign hr_eq = (hour_alarm_val_i == {afternoon_indicator_i, hours_counter_i});
	// (RULE4) weekday code compare
	assign wk_eq = (weekday_alarm_code_i == weekday_counter_i);
	assign any_en = hour_alarm_en_i | weekday_alarm_en_i;

	// (RULE15) all enabled fields must agree
	// (RULE13) dormant outside clock mode
	assign match_o = rtc_mode_i & any_en
		& (~hour_alarm_en_i | hr_eq)
		& (~weekday_alarm_en_i | wk_eq);
endmodule // rtcag_alarm_match
`default_nettype wire

// ===== hw/rtcag_alarm_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcag_map.svh"
// How it works
// (RULE1) Software keeps hour alarm within format range
// (RULE2) Software keeps afternoon select zero in 24h
// (RULE3) Weekday code 0..6, never seven
// (RULE4) Weekday compare only while its enable set
// (RULE5) Full match sets the alarm flag
// (RULE6) Interrupt needs flag and interrupt enable
// (RULE7) Software writes weekday alarm when not busy
// (RULE8) Unassigned alarm and guard bits read zero
// (RULE9) Clock mode: time writes need unlock
// (RULE10) Unlock bit stays until software clears
// (RULE11) Software unlocks, writes, then relocks
// (RULE12) Timer mode: unlock guards minutes only
// (RULE13) Weekday compare only in clock mode
// (RULE14) Hour compare only while its enable set
// (RULE15) All enabled fields must match together
// (RULE16) Soft reset clears alarms, keeps guard top
module rtcag_alarm_guard (
	input  wire logic                   core_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   ce_i,
	input  wire logic [`RTCAG_AW-1:0]   addr_i,
	input  wire logic [`RTCAG_DW-1:0]   wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	input  wire logic                   update_busy_i,
	output logic      [`RTCAG_DW-1:0]   rd_data_o,
	output logic                        alarm_irq_o
);
	logic [`RTCAG_SEC_W-1:0]   sec_reg;
	logic [`RTCAG_MIN_W-1:0]   min_reg;
	logic [`RTCAG_HR_W-1:0]    hr_reg;
	logic [`RTCAG_WK_W-1:0]    wk_reg;
	logic [`RTCAG_DAY_W-1:0]   day_reg;
	logic [`RTCAG_MON_W-1:0]   mon_reg;
	logic [`RTCAG_YR_W-1:0]    yr_reg;
	logic [`RTCAG_HRALM_W-1:0] hr_alm_reg;
	logic                      hr_alm_en_reg;
	logic [`RTCAG_WK_W-1:0]    wk_alm_reg;
	logic                      wk_alm_en_reg;
	logic                      guard_unlock_reg;
	logic                      guard_rsvd_reg;
	rtcag_pkg::rtcag_mode_t    mode_reg;
	logic                      hour_format_24_sel_reg;
	logic                      pm_reg;
	logic                      alarm_flag_reg;
	logic                      alarm_flag_next;
	logic                      alarm_irq_en_reg;
	logic                      match_prev_reg;
	logic                      irq_reg;
	logic [`RTCAG_DW-1:0]      rd_data_reg;
	logic [`RTCAG_DW-1:0]      rd_mux;
	logic                      alarm_match;
	logic                      match_rise;
	logic                      soft_rst;
	logic                      rtc_mode;
	logic                      time_wr_ok;
	logic                      min_wr_ok;
	logic                      flag_clr;

	// Write strobe aimed at one register
	function automatic logic is_wr(input logic [`RTCAG_AW-1:0] a);
		is_wr = wr_i & (addr_i == a);
	endfunction

	assign rtc_mode = (mode_reg == rtcag_pkg::RTCAG_MODE_RTC);

	// Soft reset is a write-one pulse, never stored.
	// A process, not an assign: the decode function reads strobe and
	// address itself, and an assign would not wake up when they change.
	always_comb begin
		soft_rst = is_wr(`RTCAG_A_CTRL) & wdata_i[`RTCAG_SRST_BIT];
	end

	// (RULE9) clock mode needs unlock
	// (RULE12) timer mode frees all but minutes
	assign time_wr_ok = guard_unlock_reg | ~rtc_mode;
	assign min_wr_ok  = guard_unlock_reg;

	// Guarded time registers, dropped silently when locked
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sec_reg <= '0;
			hr_reg  <= '0;
			wk_reg  <= '0;
			day_reg <= '0;
			mon_reg <= '0;
			yr_reg  <= '0;
		end else if (ce_i && time_wr_ok) begin
			if (is_wr(`RTCAG_A_SEC)) begin
				sec_reg <= wdata_i[`RTCAG_SEC_W-1:0];
			end
			if (is_wr(`RTCAG_A_HR)) begin
				hr_reg <= wdata_i[`RTCAG_HR_W-1:0];
			end
			if (is_wr(`RTCAG_A_WK)) begin
				wk_reg <= wdata_i[`RTCAG_WK_W-1:0];
			end
			if (is_wr(`RTCAG_A_DAY)) begin
				day_reg <= wdata_i[`RTCAG_DAY_W-1:0];
			end
			if (is_wr(`RTCAG_A_MON)) begin
				mon_reg <= wdata_i[`RTCAG_MON_W-1:0];
			end
			if (is_wr(`RTCAG_A_YR)) begin
				yr_reg <= wdata_i[`RTCAG_YR_W-1:0];
			end
		end
	end

	// (RULE12) minutes guarded in both modes
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			min_reg <= '0;
		end else if (ce_i && min_wr_ok && is_wr(`RTCAG_A_MIN)) begin
			min_reg <= wdata_i[`RTCAG_MIN_W-1:0];
		end
	end

	// Control: mode and format free, afternoon bit guarded
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_reg <= rtcag_pkg::RTCAG_MODE_RTC;
			hour_format_24_sel_reg <= 1'b0;
			pm_reg   <= 1'b0;
		end else if (ce_i && is_wr(`RTCAG_A_CTRL)) begin
			mode_reg <= wdata_i[`RTCAG_MODE_BIT] ? rtcag_pkg::RTCAG_MODE_CMT
			                                     : rtcag_pkg::RTCAG_MODE_RTC;
			hour_format_24_sel_reg <= wdata_i[`RTCAG_HOUR_FORMAT_24_SEL_BIT];
			// (RULE9) afternoon bit is guarded
			if (time_wr_ok) begin
				pm_reg <= wdata_i[`RTCAG_PM_BIT];
			end
		end
	end

	// Alarm registers; soft reset wins over a same-cycle write
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hr_alm_reg    <= '0;
			hr_alm_en_reg <= 1'b0;
			wk_alm_reg    <= '0;
			wk_alm_en_reg <= 1'b0;
		end else if (ce_i) begin
			// (RULE16) alarm registers cleared
			if (soft_rst) begin
				hr_alm_reg    <= '0;
				hr_alm_en_reg <= 1'b0;
				wk_alm_reg    <= '0;
				wk_alm_en_reg <= 1'b0;
			end else begin
				if (is_wr(`RTCAG_A_HRALM)) begin
					hr_alm_reg    <= wdata_i[`RTCAG_HRALM_W-1:0];
					hr_alm_en_reg <= wdata_i[`RTCAG_EN_BIT];
				end
				// (RULE8) unassigned bits not stored
				if (is_wr(`RTCAG_A_WKALM)) begin
					wk_alm_reg    <= wdata_i[`RTCAG_WK_W-1:0];
					wk_alm_en_reg <= wdata_i[`RTCAG_EN_BIT];
				end
			end
		end
	end

	// (RULE10) unlock only changes on software write
	// (RULE16) soft reset leaves top two bits
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			guard_unlock_reg <= 1'b0;
			guard_rsvd_reg   <= 1'b0;
		end else if (ce_i && is_wr(`RTCAG_A_GUARD)) begin
			guard_unlock_reg <= wdata_i[`RTCAG_GUARD_BIT];
			guard_rsvd_reg   <= wdata_i[`RTCAG_RSVD_BIT];
		end
	end

	rtcag_alarm_match u_match (
		.rtc_mode_i            (rtc_mode),
		.hour_alarm_en_i       (hr_alm_en_reg),
		.hour_alarm_val_i      (hr_alm_reg),
		.afternoon_indicator_i (pm_reg),
		.hours_counter_i       (hr_reg),
		.weekday_alarm_en_i    (wk_alm_en_reg),
		.weekday_alarm_code_i  (wk_alm_reg),
		.weekday_counter_i     (wk_reg),
		.match_o               (alarm_match)
	);

	// Flag sets once per match episode, else a clear could never stick
	assign match_rise = alarm_match & ~match_prev_reg;
	// Same wake-up hazard as the soft reset decode
	always_comb begin
		flag_clr = is_wr(`RTCAG_A_IRQST) & wdata_i[`RTCAG_ALF_BIT];
	end
	// (RULE5) set beats write-one clear
	assign alarm_flag_next = match_rise | (alarm_flag_reg & ~flag_clr);

	// Flag, enable and match history
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_flag_reg   <= 1'b0;
			alarm_irq_en_reg <= 1'b0;
			match_prev_reg   <= 1'b0;
		end else if (ce_i) begin
			alarm_flag_reg <= alarm_flag_next;
			match_prev_reg <= alarm_match;
			if (is_wr(`RTCAG_A_IRQEN)) begin
				alarm_irq_en_reg <= wdata_i[`RTCAG_ALF_BIT];
			end
		end
	end

	// (RULE6) level request from flag and enable
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			irq_reg <= alarm_flag_reg & alarm_irq_en_reg;
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_mux = '0;
		unique case (addr_i)
			`RTCAG_A_SEC: begin
				rd_mux = {update_busy_i, sec_reg};
			end
			`RTCAG_A_MIN: begin
				rd_mux = {1'b0, min_reg};
			end
			`RTCAG_A_HR: begin
				rd_mux = {2'b00, hr_reg};
			end
			`RTCAG_A_WK: begin
				rd_mux = {5'h00, wk_reg};
			end
			`RTCAG_A_DAY: begin
				rd_mux = {2'b00, day_reg};
			end
			`RTCAG_A_MON: begin
				rd_mux = {3'h0, mon_reg};
			end
			`RTCAG_A_YR: begin
				rd_mux = yr_reg;
			end
			`RTCAG_A_CTRL: begin
				rd_mux[`RTCAG_MODE_BIT] = ~rtc_mode;
				rd_mux[`RTCAG_HOUR_FORMAT_24_SEL_BIT] = hour_format_24_sel_reg;
				rd_mux[`RTCAG_PM_BIT]   = pm_reg;
			end
			`RTCAG_A_IRQST: begin
				rd_mux[`RTCAG_ALF_BIT] = alarm_flag_reg;
			end
			`RTCAG_A_IRQEN: begin
				rd_mux[`RTCAG_ALF_BIT] = alarm_irq_en_reg;
			end
			`RTCAG_A_HRALM: begin
				rd_mux = {hr_alm_en_reg, hr_alm_reg};
			end
			// (RULE8) gap bits read zero
			`RTCAG_A_WKALM: begin
				rd_mux = {wk_alm_en_reg, 4'h0, wk_alm_reg};
			end
			`RTCAG_A_GUARD: begin
				rd_mux = {guard_unlock_reg, guard_rsvd_reg, 6'h00};
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Read data shows only in the cycle after the strobe
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_reg <= `RTCAG_RST_BYTE;
		end else if (ce_i) begin
			rd_data_reg <= rd_i ? rd_mux : `RTCAG_RST_BYTE;
		end
	end

	assign rd_data_o   = rd_data_reg;
	assign alarm_irq_o = irq_reg;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	wk_compare_a: assert property ( // (RULE4)
		alarm_match && wk_alm_en_reg |-> wk_alm_reg == wk_reg
	) else $error("weekday alarm fired on mismatch");

	flag_set_a: assert property ( // (RULE5)
		ce_i && alarm_match && !match_prev_reg |=> alarm_flag_reg
	) else $error("alarm flag not set on match");

	irq_gate_a: assert property ( // (RULE6)
		$past(ce_i) |-> alarm_irq_o == $past(alarm_flag_reg && alarm_irq_en_reg)
	) else $error("interrupt not flag and enable");

	rsvd_zero_a: assert property ( // (RULE8)
		ce_i && rd_i && addr_i == `RTCAG_A_WKALM
		|=> (rd_data_o & `RTCAG_WK_RSVD_MSK) == 8'h00
	) else $error("weekday alarm gap bits read nonzero");

	rsvd_guard_a: assert property ( // (RULE8)
		ce_i && rd_i && addr_i == `RTCAG_A_GUARD
		|=> (rd_data_o & `RTCAG_GD_RSVD_MSK) == 8'h00
	) else $error("guard low bits read nonzero");

	guard_block_a: assert property ( // (RULE9)
		ce_i && rtc_mode && !guard_unlock_reg && wr_i && addr_i == `RTCAG_A_HR
		|=> $stable(hr_reg)
	) else $error("locked hour write took effect");

	guard_hold_a: assert property ( // (RULE10)
		guard_unlock_reg && !(wr_i && addr_i == `RTCAG_A_GUARD) |=> guard_unlock_reg
	) else $error("unlock bit cleared by itself");

	cmt_min_a: assert property ( // (RULE12)
		ce_i && !rtc_mode && !guard_unlock_reg && wr_i && addr_i == `RTCAG_A_MIN
		|=> $stable(min_reg)
	) else $error("locked minute write took effect");

	rtc_only_a: assert property ( // (RULE13)
		alarm_match |-> rtc_mode
	) else $error("alarm matched outside clock mode");

	hr_compare_a: assert property ( // (RULE14)
		alarm_match && hr_alm_en_reg |-> hr_alm_reg == {pm_reg, hr_reg}
	) else $error("hour alarm fired on mismatch");

	none_en_a: assert property ( // (RULE15)
		!hr_alm_en_reg && !wk_alm_en_reg |-> !alarm_match
	) else $error("alarm with no field enabled");

	srst_clear_a: assert property ( // (RULE16)
		ce_i && soft_rst |=> !wk_alm_en_reg && wk_alm_reg == '0
			&& guard_unlock_reg == $past(guard_unlock_reg)
	) else $error("soft reset effect wrong");

	flag_seen_c: cover property (ce_i && match_rise ##1 alarm_flag_reg);
	irq_seen_c: cover property (alarm_irq_o);
	unlock_wr_c: cover property (
		ce_i && guard_unlock_reg && rtc_mode && wr_i && addr_i == `RTCAG_A_HR
	);
	srst_seen_c: cover property (ce_i && soft_rst && guard_unlock_reg);
endmodule // rtcag_alarm_guard
`default_nettype wire

// ===== tb/test_rtc_alarm_write_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcag_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_rtc_alarm_write_guard;
	logic                 clk    = 1'b0;
	logic                 resetn = 1'b0;
	logic                 ce     = 1'b1;
	logic [`RTCAG_AW-1:0] addr   = '0;
	logic [`RTCAG_DW-1:0] wdata  = '0;
	logic                 wr     = 1'b0;
	logic                 rd     = 1'b0;
	logic                 busy   = 1'b0;
	logic [`RTCAG_DW-1:0] rdata;
	logic                 irq;
	int                   fails  = 0;
	int                   checks_done = 0;
	// Field masks of the seven time registers, seconds first
	logic [7:0]           tmask [7] = '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};

	// Clock of 10 ns period
	always #5 clk = ~clk;

	rtcag_alarm_guard u_dut (
		.core_clk_i    (clk),
		.resetn_i      (resetn),
		.ce_i          (ce),
		.addr_i        (addr),
		.wdata_i       (wdata),
		.wr_i          (wr),
		.rd_i          (rd),
		.update_busy_i (busy),
		.rd_data_o     (rdata),
		.alarm_irq_o   (irq)
	);

	// One write cycle; the idle edge after it keeps strobes single
	task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd_chk(input logic [8:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask

	// Interrupt is registered one edge behind the flag
	task automatic irq_chk(input logic e, input string nm);
		repeat (2) @(posedge clk);
		#1;
		`CHK(nm, e, irq)
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs well under 2000 cycles
	initial begin
		#100000;
		fails++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd_chk(`RTCAG_A_WKALM, 8'h00, "weekday alarm reset"); // reset value
		rd_chk(`RTCAG_A_GUARD, 8'h00, "guard reset"); // reset value
		rd_chk(`RTCAG_A_IRQST, 8'h00, "flag reset");
		wr_reg(9'h17a, 8'hff);
		rd_chk(9'h17a, 8'h00, "unmapped");
		// Locked time registers drop writes
		for (int i = 0; i < 7; i++) begin
			wr_reg(`RTCAG_A_SEC + 9'(i), 8'h55);
			rd_chk(`RTCAG_A_SEC + 9'(i), 8'h00, "locked time write"); // locked
		end
		wr_reg(`RTCAG_A_GUARD, 8'hff);
		rd_chk(`RTCAG_A_GUARD, 8'hc0, "guard unused bits"); // guard zeros
		for (int i = 0; i < 7; i++) begin
			wr_reg(`RTCAG_A_SEC + 9'(i), 8'h10 + 8'(i));
			rd_chk(`RTCAG_A_SEC + 9'(i), (8'h10 + 8'(i)) & tmask[i], "open time write"); // open
		end
		rd_chk(`RTCAG_A_GUARD, 8'hc0, "guard held"); // unlock kept
		wr_reg(`RTCAG_A_CTRL, 8'h40);
		rd_chk(`RTCAG_A_CTRL, 8'h40, "afternoon open"); // indicator open
		wr_reg(`RTCAG_A_GUARD, 8'h00);
		wr_reg(`RTCAG_A_CTRL, 8'h00);
		rd_chk(`RTCAG_A_CTRL, 8'h40, "afternoon locked"); // indicator locked
		wr_reg(`RTCAG_A_HR, 8'h05);
		rd_chk(`RTCAG_A_HR, 8'h12, "relocked hours"); // relock works
		// Busy shows in seconds bit 7; alarm writes wait for it low
		busy <= 1'b1;
		rd_chk(`RTCAG_A_SEC, 8'h90, "busy shown");
		busy <= 1'b0;
		rd_chk(`RTCAG_A_SEC, 8'h10, "busy clear"); // idle before alarm write
		// Weekday compare; counter holds 3
		wr_reg(`RTCAG_A_WKALM, 8'h7b);
		rd_chk(`RTCAG_A_WKALM, 8'h03, "weekday unused bits"); // alarm zeros
		rd_chk(`RTCAG_A_IRQST, 8'h00, "weekday disabled"); // no compare
		wr_reg(`RTCAG_A_WKALM, 8'h83);
		rd_chk(`RTCAG_A_IRQST, 8'h01, "weekday match"); // flag set
		irq_chk(1'b0, "irq masked"); // mask off
		wr_reg(`RTCAG_A_IRQEN, 8'h01);
		irq_chk(1'b1, "irq unmasked"); // mask on
		wr_reg(`RTCAG_A_IRQST, 8'h01);
		irq_chk(1'b0, "irq cleared"); // flag cleared
		// Every weekday code, each beside a wrong one
		wr_reg(`RTCAG_A_GUARD, 8'h80);
		for (int d = 0; d < 7; d++) begin
			wr_reg(`RTCAG_A_WK, 8'(d));
			wr_reg(`RTCAG_A_IRQST, 8'h01);
			wr_reg(`RTCAG_A_WKALM, 8'h80 | 8'((d + 1) % 7));
			rd_chk(`RTCAG_A_IRQST, 8'h00, "weekday mismatch"); // codes
			wr_reg(`RTCAG_A_WKALM, 8'h80 | 8'(d));
			rd_chk(`RTCAG_A_IRQST, 8'h01, "weekday code match"); // codes
		end
		// Hour compare with afternoon select; weekday counter is 6
		wr_reg(`RTCAG_A_HR, 8'h11);
		wr_reg(`RTCAG_A_IRQST, 8'h01);
		wr_reg(`RTCAG_A_WKALM, 8'h85);
		wr_reg(`RTCAG_A_HRALM, 8'hd1); // hour within 12h range
		rd_chk(`RTCAG_A_IRQST, 8'h00, "one field off"); // all fields
		wr_reg(`RTCAG_A_WKALM, 8'h86);
		rd_chk(`RTCAG_A_IRQST, 8'h01, "both fields"); // all fields
		wr_reg(`RTCAG_A_HRALM, 8'h91);
		wr_reg(`RTCAG_A_WKALM, 8'h00);
		wr_reg(`RTCAG_A_IRQST, 8'h01);
		rd_chk(`RTCAG_A_IRQST, 8'h00, "afternoon mismatch"); // select compared
		wr_reg(`RTCAG_A_HRALM, 8'hd1);
		rd_chk(`RTCAG_A_IRQST, 8'h01, "hour match"); // hour compare
		wr_reg(`RTCAG_A_IRQEN, 8'h00);
		irq_chk(1'b0, "irq mask with flag"); // needs enable
		// 24-hour format; afternoon indicator drops, select stays zero
		wr_reg(`RTCAG_A_CTRL, 8'h20);
		rd_chk(`RTCAG_A_CTRL, 8'h20, "24h format"); // indicator open
		wr_reg(`RTCAG_A_HR, 8'h17);
		wr_reg(`RTCAG_A_IRQST, 8'h01);
		rd_chk(`RTCAG_A_IRQST, 8'h00, "24h old alarm off"); // select compared
		wr_reg(`RTCAG_A_HRALM, 8'h97); // select zero in 24h
		rd_chk(`RTCAG_A_IRQST, 8'h01, "24h hour match"); // hour compare
		// Compare timer mode
		wr_reg(`RTCAG_A_HRALM, 8'h00);
		wr_reg(`RTCAG_A_IRQST, 8'h01);
		wr_reg(`RTCAG_A_CTRL, 8'h02);
		wr_reg(`RTCAG_A_WKALM, 8'h86);
		rd_chk(`RTCAG_A_IRQST, 8'h00, "timer mode compare"); // clock mode only
		wr_reg(`RTCAG_A_GUARD, 8'h00);
		wr_reg(`RTCAG_A_HR, 8'h07);
		rd_chk(`RTCAG_A_HR, 8'h07, "timer mode hours"); // hours free
		wr_reg(`RTCAG_A_MIN, 8'h33);
		rd_chk(`RTCAG_A_MIN, 8'h11, "timer mode minutes locked"); // minutes guarded
		wr_reg(`RTCAG_A_GUARD, 8'h80);
		wr_reg(`RTCAG_A_MIN, 8'h33);
		rd_chk(`RTCAG_A_MIN, 8'h33, "timer mode minutes open"); // minutes open
		wr_reg(`RTCAG_A_CTRL, 8'h00);
		rd_chk(`RTCAG_A_IRQST, 8'h01, "clock mode compare"); // compare resumes
		// Soft reset keeps the two top guard bits
		wr_reg(`RTCAG_A_GUARD, 8'hc0);
		wr_reg(`RTCAG_A_HRALM, 8'h89);
		wr_reg(`RTCAG_A_CTRL, 8'h01);
		rd_chk(`RTCAG_A_WKALM, 8'h00, "soft reset weekday"); // alarm cleared
		rd_chk(`RTCAG_A_HRALM, 8'h00, "soft reset hour"); // hour alarm cleared
		rd_chk(`RTCAG_A_GUARD, 8'hc0, "soft reset guard"); // top bits kept
		// Clock enable low freezes every register, writes included
		ce <= 1'b0;
		wr_reg(`RTCAG_A_HRALM, 8'h85);
		ce <= 1'b1;
		rd_chk(`RTCAG_A_HRALM, 8'h00, "frozen write");
		give_verdict();
	end
endmodule // test_rtc_alarm_write_guard
`default_nettype wire
